// ### rtl/evc_event_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "evc_map.svh"
module evc_event_ctrl
   import evc_pkg::*;
#(
   parameter int unsigned TICK_PRESCALE = `EVC_CLK_HZ / `EVC_TICK0_HZ,
   parameter logic [23:0] DELAY0_CYCLES = 24'h0000c8,
   parameter logic [23:0] DELAY1_CYCLES = 24'h000190
) (
   input wire logic clk_i,              // system clock, 200 MHz
   input wire logic resetn_i,           // async reset, active low
   input wire logic wr_en_i,            // register write strobe
   input wire logic [7:0] wr_data_i,    // register write data
   output logic [7:0] rd_data_o,        // register read data
   input wire logic event_pin_i,        // external event pin, asynchronous
   output logic event_pulse_o,          // one-cycle event detected
   output logic event_level_o,          // filtered active level
   input wire logic off_req_i,          // request to switch clock output off
   input wire logic bus_stop_i,         // bus stop seen, one-cycle pulse
   input wire logic out_delay_select_i, // delay length select
   output logic clock_output_en_o       // clock output running
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_r, ctrl_nxt;
   logic out_delay_enable, event_polarity;
   evc_filter_type event_filter_period;
   logic tick256, tick64, tick8, sel_tick;

   assign out_delay_enable = ctrl_r[`EVC_BIT_DELAY_EN];
   assign event_polarity = ctrl_r[`EVC_BIT_POLARITY];
   assign event_filter_period = evc_filter_type'(ctrl_r[`EVC_FILTER_HI:`EVC_FILTER_LO]);
   assign rd_data_o = ctrl_r;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_en_i) begin
         ctrl_nxt = wr_data_i;
         ctrl_nxt[`EVC_ZERO_HI:`EVC_ZERO_LO] = 3'h0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_r <= `EVC_CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   evc_tick_gen #(
      .PRESCALE(TICK_PRESCALE)
   ) u_tick (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .tick256_o(tick256),
      .tick64_o(tick64),
      .tick8_o(tick8)
   );

   always_comb begin
      case (event_filter_period)
         EVC_FILT_256: sel_tick = tick256;
         EVC_FILT_64: sel_tick = tick64;
         EVC_FILT_8: sel_tick = tick8;
         default: sel_tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   logic pin_s1_r, pin_s2_r, pin_d_r, samp_r;
   logic samp_nxt, pulse_nxt, level_nxt;
   logic pin_act, pin_d_act, samp_act;

   always_comb begin
      pin_act = (pin_s2_r == event_polarity);
      pin_d_act = (pin_d_r == event_polarity);
      samp_act = (samp_r == event_polarity);
      samp_nxt = sel_tick ? pin_s2_r : samp_r;
      if (event_filter_period == EVC_FILT_NONE) begin
         pulse_nxt = pin_act && !pin_d_act;
         level_nxt = 1'b0;
      end else begin
         pulse_nxt = sel_tick && pin_act && !samp_act;
         level_nxt = sel_tick ? pin_act : samp_act;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_d_r <= 1'b0;
         samp_r <= 1'b0;
         event_pulse_o <= 1'b0;
         event_level_o <= 1'b0;
      end else begin
         pin_s1_r <= event_pin_i;
         pin_s2_r <= pin_s1_r;
         pin_d_r <= pin_s2_r;
         samp_r <= samp_nxt;
         event_pulse_o <= pulse_nxt;
         event_level_o <= level_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // with bit 7 set, switch-off waits for the bus stop, then the selected delay; with it clear, switch-off is at once
   evc_state_type state_r, state_nxt;
   logic [23:0] cnt_r, cnt_nxt;
   logic armed_r, armed_nxt;
   logic en_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      armed_nxt = armed_r;
      case (state_r)
         EVC_ON: begin
            if (off_req_i) begin
               if (out_delay_enable) begin
                  state_nxt = EVC_HOLD;
                  armed_nxt = 1'b0;
               end else begin
                  state_nxt = EVC_OFF;
               end
            end
         end
         EVC_HOLD: begin
            if (!off_req_i) begin
               state_nxt = EVC_ON;
            end else if (!armed_r) begin
               if (bus_stop_i) begin
                  armed_nxt = 1'b1;
                  cnt_nxt = out_delay_select_i ? DELAY1_CYCLES : DELAY0_CYCLES;
               end
            end else if (cnt_r <= 24'h000001) begin
               state_nxt = EVC_OFF;
            end else begin
               cnt_nxt = cnt_r - 24'h000001;
            end
         end
         EVC_OFF: begin
            if (!off_req_i) begin
               state_nxt = EVC_ON;
            end
         end
         default: state_nxt = EVC_ON;
      endcase
      en_nxt = (state_nxt != EVC_OFF);
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= EVC_ON;
         cnt_r <= 24'h000000;
         armed_r <= 1'b0;
         clock_output_en_o <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         armed_r <= armed_nxt;
         clock_output_en_o <= en_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   ro_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_en_i |=> rd_data_o[3:1] == 3'h0 && rd_data_o[7:4] == $past(wr_data_i[7:4]))
      else $error("zero field or written bits wrong");
   fall_edge_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (event_filter_period == EVC_FILT_NONE && !event_polarity && !wr_en_i
       && pin_d_r && !pin_s2_r) |=> event_pulse_o)
      else $error("falling edge not reported");
   rise_edge_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (event_filter_period == EVC_FILT_NONE && event_polarity && !wr_en_i
       && !pin_d_r && pin_s2_r) |=> event_pulse_o)
      else $error("rising edge not reported");
   no_filter_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (event_filter_period == EVC_FILT_NONE) |=> !event_level_o)
      else $error("level reported without filter");
   filt_tick_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (event_pulse_o && $past(event_filter_period) != EVC_FILT_NONE) |-> $past(sel_tick))
      else $error("filtered event off the sample tick");
   rate_map_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (event_filter_period == EVC_FILT_8 && tick64 && !tick8) |-> !sel_tick)
      else $error("wrong sampling rate selected");
   nodelay_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_r == EVC_ON && off_req_i && !out_delay_enable) |=> !clock_output_en_o)
      else $error("clock output not switched off at once");
   delay_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_r == EVC_ON && off_req_i && out_delay_enable) ##1 off_req_i[*2]
      |-> clock_output_en_o)
      else $error("clock output switched off before delay");
endmodule // evc_event_ctrl
`default_nettype wire

// ### rtl/evc_map.svh
// Functional notes
// - bit 7 set delays clock output switch-off after bus stop; clear means no delay.
// - polarity 0: falling edge when filter is 00, else low level is the event.
// - polarity 1: rising edge when filter is 00, else high level is the event.
// - filter field zero: no filtering, plain edge detection on the event pin.
// - nonzero filter: sample pin at 3.9, 15.6 or 125 ms; edge and level detection.
// - unused field reads zero always, writes to it have no effect.
`ifndef EVC_MAP_SVH
`define EVC_MAP_SVH
`define EVC_CTRL_RESET 8'h00
`define EVC_BIT_DELAY_EN 7
`define EVC_BIT_POLARITY 6
`define EVC_FILTER_HI 5
`define EVC_FILTER_LO 4
`define EVC_ZERO_HI 3
`define EVC_ZERO_LO 1
`define EVC_BIT_SYNC 0
`define EVC_CLK_HZ 200000000
`define EVC_TICK0_HZ 256
`define EVC_TICK1_HZ 64
`define EVC_TICK2_HZ 8
`define EVC_TSP0_US 3900
`define EVC_TSP1_US 15600
`define EVC_TSP2_US 125000
`endif

// ### rtl/evc_pkg.sv
package evc_pkg;
   typedef enum logic [1:0] {
      EVC_FILT_NONE = 2'h0,
      EVC_FILT_256 = 2'h1,
      EVC_FILT_64 = 2'h2,
      EVC_FILT_8 = 2'h3
   } evc_filter_type;
   typedef enum logic [2:0] {
      EVC_ON = 3'b001,
      EVC_HOLD = 3'b010,
      EVC_OFF = 3'b100
   } evc_state_type;
endpackage

// ### rtl/evc_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "evc_map.svh"
module evc_tick_gen #(
   parameter int unsigned PRESCALE = `EVC_CLK_HZ / `EVC_TICK0_HZ
) (
   input wire logic clk_i,      // system clock
   input wire logic resetn_i,   // async reset, active low
   output logic tick256_o,      // 256 Hz enable pulse
   output logic tick64_o,       // 64 Hz enable pulse
   output logic tick8_o         // 8 Hz enable pulse
);
   localparam int unsigned SUB64 = `EVC_TICK0_HZ / `EVC_TICK1_HZ;
   localparam int unsigned SUB8 = `EVC_TICK0_HZ / `EVC_TICK2_HZ;
   logic [23:0] pre_r, pre_nxt;
   logic [4:0] sub_r, sub_nxt;
   logic t256_nxt, t64_nxt, t8_nxt;

   always_comb begin
      t256_nxt = (pre_r == 24'(PRESCALE - 1));
      pre_nxt = t256_nxt ? 24'h000000 : pre_r + 24'h000001;
      sub_nxt = t256_nxt ? sub_r + 5'h01 : sub_r;
      t64_nxt = t256_nxt && (sub_r[1:0] == 2'(SUB64 - 1));
      t8_nxt = t256_nxt && (sub_r == 5'(SUB8 - 1));
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pre_r <= 24'h000000;
         sub_r <= 5'h00;
         tick256_o <= 1'b0;
         tick64_o <= 1'b0;
         tick8_o <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         sub_r <= sub_nxt;
         tick256_o <= t256_nxt;
         tick64_o <= t64_nxt;
         tick8_o <= t8_nxt;
      end
   end
endmodule // evc_tick_gen
`default_nettype wire

// ### verif/evc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module evc_host_model (
   input wire logic clk_i,       // system clock
   output logic wr_en_o,         // write strobe
   output logic [7:0] wr_data_o, // write data
   output logic bus_stop_o       // bus stop pulse
);
   initial begin
      wr_en_o = 1'b0;
      wr_data_o = 8'h00;
      bus_stop_o = 1'b0;
   end
   task automatic wr(input logic [7:0] d);
      @(posedge clk_i);
      #1 wr_en_o = 1'b1;
      wr_data_o = d;
      @(posedge clk_i);
      #1 wr_en_o = 1'b0;
      wr_data_o = ~d;
   endtask
   task automatic stop();
      @(posedge clk_i);
      #1 bus_stop_o = 1'b1;
      @(posedge clk_i);
      #1 bus_stop_o = 1'b0;
   endtask
endmodule // evc_host_model
`default_nettype wire

// ### verif/evc_event_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module evc_event_ctrl_bench;
   import evc_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i, pin, off_req, dsel;
   logic wr_en, stp, ev_p, ev_l, ck_en;
   logic [7:0] wr_d, rd;
   int fail_count = 0, checks = 0;
   int bnd [3] = '{12, 36, 262};
   always #2.5 clk_i = ~clk_i;
   evc_host_model u_evc_host_model (.clk_i(clk_i), .wr_en_o(wr_en),
      .wr_data_o(wr_d), .bus_stop_o(stp));
   evc_event_ctrl #(.TICK_PRESCALE(8), .DELAY0_CYCLES(24'h000004),
      .DELAY1_CYCLES(24'h000008)) u_evc_event_ctrl (.clk_i(clk_i),
      .resetn_i(resetn_i), .wr_en_i(wr_en), .wr_data_i(wr_d),
      .rd_data_o(rd), .event_pin_i(pin), .event_pulse_o(ev_p),
      .event_level_o(ev_l), .off_req_i(off_req), .bus_stop_i(stp),
      .out_delay_select_i(dsel), .clock_output_en_o(ck_en));
   task automatic end_sim();
      if (fail_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   function automatic logic sg(input int s);
      return s == 0 ? ev_p : s == 1 ? ev_l : ck_en;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wt(input int s, input int n, input logic e);
      for (int k = 0; k < n; k++) begin
         cyc(1);
         if (sg(s) === e) break;
      end
      chk(sg(s), e);
   endtask
   task automatic hold(input int s, input int n, input logic e);
      repeat (n) begin
         cyc(1);
         chk(sg(s), e);
      end
   endtask
   initial begin
      #100000;
      fail_count++;
      end_sim();
   end
   initial begin
      resetn_i = 1'b0;
      pin = 1'b1;
      off_req = 1'b0;
      dsel = 1'b0;
      cyc(5);
      chk(rd, 8'h00);
      chk(ck_en, 1'b1);
      resetn_i = 1'b1;
      u_evc_host_model.wr(8'hff);
      chk(rd, 8'hf1);
      u_evc_host_model.wr(8'h0e);
      chk(rd, 8'h00);
      for (int p = 0; p < 2; p++) begin
         u_evc_host_model.wr({1'b0, p[0], 6'h00});
         pin = ~p[0];
         cyc(8);
         pin = p[0];
         wt(0, 6, 1'b1);
         pin = ~p[0];
         hold(0, 8, 1'b0);
         chk(ev_l, 1'b0);
         for (int c = 1; c < 4; c++) begin
            u_evc_host_model.wr({1'b0, p[0], c[1:0], 4'h0});
            cyc(300);
            chk(ev_l, 1'b0);
            pin = p[0];
            wt(1, bnd[c-1], 1'b1);
            chk(ev_p, 1'b1);
            pin = ~p[0];
            wt(1, bnd[c-1], 1'b0);
         end
      end
      u_evc_host_model.wr(8'h00);
      off_req = 1'b1;
      wt(2, 2, 1'b0);
      off_req = 1'b0;
      wt(2, 3, 1'b1);
      u_evc_host_model.wr(8'h80);
      off_req = 1'b1;
      hold(2, 20, 1'b1);
      u_evc_host_model.stop();
      wt(2, 8, 1'b0);
      off_req = 1'b0;
      wt(2, 3, 1'b1);
      dsel = 1'b1;
      off_req = 1'b1;
      u_evc_host_model.stop();
      hold(2, 5, 1'b1);
      wt(2, 8, 1'b0);
      off_req = 1'b0;
      wt(2, 3, 1'b1);
      off_req = 1'b1;
      u_evc_host_model.stop();
      off_req = 1'b0;
      hold(2, 15, 1'b1);
      end_sim();
   end
endmodule // evc_event_ctrl_bench
`default_nettype wire
